// file: rtl/ftbs_core.sv
`timescale 1ns/1ns
`default_nettype none
module ftbs_core (
  input  wire logic                        clk,
  input  wire logic                        rst_b,
  input  wire logic [ftbs_pkg::ADDR_W-1:0] addr,
  input  wire logic [ftbs_pkg::DATA_W-1:0] dq_in,
  output logic      [ftbs_pkg::DATA_W-1:0] dq_out,
  output logic                             dq_oe,
  input  wire logic                        proc_addr_strobe_b,
  input  wire logic                        ctrl_addr_strobe_b,
  input  wire logic                        burst_advance_b,
  input  wire logic                        all_bytes_write_b,
  input  wire logic                        byte_write_gate_b,
  input  wire logic [ftbs_pkg::LANES-1:0]  byte_lane_writes_b,
  input  wire logic                        burst_order_select,
  input  wire logic                        master_select_b,
  input  wire logic                        select_high,
  input  wire logic                        select_low_b,
  input  wire logic                        output_enable_b,
  input  wire logic                        sleep_request
);
  // storage array, no reset: contents survive sleep
  logic [ftbs_pkg::DATA_W-1:0] mem_q [0:ftbs_pkg::DEPTH-1]; // R1

  ftbs_pkg::ftbs_state_t              state_q;
  logic [ftbs_pkg::ADDR_W-1:2]        addr_hi_q;
  logic [ftbs_pkg::BURST_W-1:0]       base_q;
  logic [ftbs_pkg::BURST_W-1:0]       cnt_q;

  logic                               awake;
  logic                               sub_sel;
  logic                               proc_start;
  logic                               ctrl_start;
  logic                               deselect;
  logic                               step;
  logic [ftbs_pkg::LANES-1:0]         wr_lanes;
  logic [ftbs_pkg::BURST_W-1:0]       cnt_d;
  logic [ftbs_pkg::BURST_W-1:0]       low_cur;
  logic [ftbs_pkg::BURST_W-1:0]       low_nxt;
  logic [ftbs_pkg::ADDR_W-1:0]        cur_addr;
  logic [ftbs_pkg::ADDR_W-1:0]        wr_addr;
  logic                               in_burst;

  assign awake = ~sleep_request; // R23
  assign sub_sel = select_high & ~select_low_b; // R2
  // processor strobe needs master select too
  assign proc_start = awake & ~proc_addr_strobe_b & ~master_select_b
                    & sub_sel; // R19 R2
  // controller strobe only when processor strobe not taken
  assign ctrl_start = awake & ~ctrl_addr_strobe_b & sub_sel
                    & (proc_addr_strobe_b | master_select_b); // R17 R19
  assign deselect = awake & ~proc_start & ~ctrl_start
                  & ((~ctrl_addr_strobe_b & ~sub_sel)
                   | (~proc_addr_strobe_b & ~master_select_b & ~sub_sel));
  assign in_burst = awake & ~proc_start & ~ctrl_start & ~deselect
                  & (state_q != ftbs_pkg::FTBS_IDLE);

  // write lane decode
  always_comb begin
    if (~all_bytes_write_b) begin
      wr_lanes = ftbs_pkg::LANES_ALL; // R11
    end else if (~byte_write_gate_b) begin
      wr_lanes = ~byte_lane_writes_b; // R12
    end else begin
      wr_lanes = ftbs_pkg::LANES_NONE; // R21
    end
  end

  // burst address order
  function automatic logic [ftbs_pkg::BURST_W-1:0] burst_low(
    input logic                         order_il,
    input logic [ftbs_pkg::BURST_W-1:0] base,
    input logic [ftbs_pkg::BURST_W-1:0] cnt
  );
    if (order_il) begin
      burst_low = base ^ cnt; // R8
    end else begin
      burst_low = base + cnt; // R9 R20
    end
  endfunction

  // advance only with both strobes high, never on a start edge
  assign step = in_burst & ~burst_advance_b
              & proc_addr_strobe_b & ctrl_addr_strobe_b; // R6 R7 R16
  assign cnt_d = step ? cnt_q + 2'h1 : cnt_q; // R20
  assign low_cur = burst_low(burst_order_select, base_q, cnt_q);
  assign low_nxt = burst_low(burst_order_select, base_q, cnt_d);
  assign cur_addr = {addr_hi_q, low_cur};
  assign wr_addr = ctrl_start ? addr : {addr_hi_q, low_nxt};

  // address register and burst counter
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addr_hi_q <= '0;
      base_q    <= ftbs_pkg::CNT_RST;
      cnt_q     <= ftbs_pkg::CNT_RST;
    end else if (proc_start | ctrl_start) begin
      addr_hi_q <= addr[ftbs_pkg::ADDR_W-1:2]; // R3 R4
      base_q    <= addr[1:0];
      cnt_q     <= ftbs_pkg::CNT_RST;
    end else if (in_burst) begin
      cnt_q     <= cnt_d; // R3 R7 R16
    end
  end

  // cycle state
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_q <= ftbs_pkg::FTBS_IDLE;
    end else if (proc_start) begin
      state_q <= ftbs_pkg::FTBS_READ; // R4 R13
    end else if (ctrl_start | in_burst) begin
      if (wr_lanes != ftbs_pkg::LANES_NONE) begin
        state_q <= ftbs_pkg::FTBS_WRITE; // R14 R18
      end else begin
        state_q <= ftbs_pkg::FTBS_READ; // R21
      end
    end else if (deselect) begin
      state_q <= ftbs_pkg::FTBS_IDLE; // R2
    end
  end

  // data pins captured into the array on the sampling edge
  always_ff @(posedge clk) begin
    if ((ctrl_start | in_burst) & wr_lanes[0]) begin
      mem_q[wr_addr][ftbs_pkg::LANE_A_LSB +: ftbs_pkg::LANE_W] <=
        dq_in[ftbs_pkg::LANE_A_LSB +: ftbs_pkg::LANE_W]; // R15
    end
    if ((ctrl_start | in_burst) & wr_lanes[1]) begin
      mem_q[wr_addr][ftbs_pkg::LANE_B_LSB +: ftbs_pkg::LANE_W] <=
        dq_in[ftbs_pkg::LANE_B_LSB +: ftbs_pkg::LANE_W]; // R15
    end
  end

  // flow-through: array read of registered address, no output stage
  assign dq_out = mem_q[cur_addr]; // R5
  // output enable is asynchronous and gated by read mode
  assign dq_oe = ~output_enable_b & awake
               & (state_q == ftbs_pkg::FTBS_READ); // R22 R14 R23

  // checks
  property p_proc_read;
    @(posedge clk) disable iff (!rst_b)
    proc_start |=> state_q == ftbs_pkg::FTBS_READ
                && cur_addr == $past(addr);
  endproperty
  a_proc_read: assert property (p_proc_read) // R4
    else $error("processor strobe did not start a read at its address");

  property p_adv_ignored;
    @(posedge clk) disable iff (!rst_b)
    (proc_start && !burst_advance_b) |=> cnt_q == ftbs_pkg::CNT_RST;
  endproperty
  a_adv_ignored: assert property (p_adv_ignored) // R6
    else $error("advance acted on the processor strobe edge");

  property p_adv_step;
    @(posedge clk) disable iff (!rst_b)
    (in_burst && !burst_advance_b && proc_addr_strobe_b
      && ctrl_addr_strobe_b) |=> cnt_q == $past(cnt_q) + 2'h1;
  endproperty
  a_adv_step: assert property (p_adv_step) // R7
    else $error("burst address failed to step");

  property p_order;
    @(posedge clk) disable iff (!rst_b)
    burst_order_select ? (low_cur == (base_q ^ cnt_q))
                       : (low_cur == base_q + cnt_q);
  endproperty
  a_order: assert property (p_order) // R8 R9
    else $error("burst sequence does not match order select");

  property p_hi_stable;
    @(posedge clk) disable iff (!rst_b)
    in_burst |=> addr_hi_q == $past(addr_hi_q);
  endproperty
  a_hi_stable: assert property (p_hi_stable) // R20
    else $error("burst altered upper address bits");

  property p_global_write;
    @(posedge clk) disable iff (!rst_b)
    (in_burst && !all_bytes_write_b) |=> state_q == ftbs_pkg::FTBS_WRITE
      && !dq_oe;
  endproperty
  a_global_write: assert property (p_global_write) // R11 R14
    else $error("global write did not enter write with drivers off");

  property p_lane_ignored;
    @(posedge clk) disable iff (!rst_b)
    (proc_start && !byte_write_gate_b && byte_lane_writes_b != 2'h3)
      |=> state_q == ftbs_pkg::FTBS_READ;
  endproperty
  a_lane_ignored: assert property (p_lane_ignored) // R13
    else $error("lane enables acted on the processor strobe edge");

  property p_ctrl_write;
    @(posedge clk) disable iff (!rst_b)
    (ctrl_start && wr_lanes != ftbs_pkg::LANES_NONE)
      |=> state_q == ftbs_pkg::FTBS_WRITE;
  endproperty
  a_ctrl_write: assert property (p_ctrl_write) // R18
    else $error("controller strobe write not taken on first edge");

  property p_master_block;
    @(posedge clk) disable iff (!rst_b)
    (master_select_b && ctrl_addr_strobe_b)
      |=> addr_hi_q == $past(addr_hi_q) && base_q == $past(base_q);
  endproperty
  a_master_block: assert property (p_master_block) // R19
    else $error("processor strobe not blocked by master select");

  property p_sleep;
    @(posedge clk) disable iff (!rst_b)
    sleep_request |-> !dq_oe ##1 (!sleep_request || cnt_q == $past(cnt_q));
  endproperty
  a_sleep: assert property (p_sleep) // R23
    else $error("activity seen during sleep");

  property p_read_mode;
    @(posedge clk) disable iff (!rst_b)
    (in_burst && all_bytes_write_b && byte_write_gate_b)
      |=> state_q == ftbs_pkg::FTBS_READ;
  endproperty
  a_read_mode: assert property (p_read_mode) // R21
    else $error("idle byte gate did not give a read");

  property p_deselect;
    @(posedge clk) disable iff (!rst_b)
    deselect |=> state_q == ftbs_pkg::FTBS_IDLE && !dq_oe;
  endproperty
  a_deselect: assert property (p_deselect) // R2
    else $error("deselect did not return to idle");

  property p_ctrl_load;
    @(posedge clk) disable iff (!rst_b)
    ctrl_start |=> cnt_q == ftbs_pkg::CNT_RST && base_q == $past(addr[1:0])
      && addr_hi_q == $past(addr[ftbs_pkg::ADDR_W-1:2]);
  endproperty
  a_ctrl_load: assert property (p_ctrl_load) // R3
    else $error("controller strobe did not load the address");

  property p_il_step;
    @(posedge clk) disable iff (!rst_b)
    (step && burst_order_select) |=> !burst_order_select
      || low_cur == {$past(low_cur[1]) ^ $past(low_cur[0]) ^ base_q[0],
                     ~$past(low_cur[0])};
  endproperty
  a_il_step: assert property (p_il_step) // R8
    else $error("interleaved burst stepped out of order");

  property p_lin_step;
    @(posedge clk) disable iff (!rst_b)
    (step && !burst_order_select) |=> burst_order_select
      || low_cur == $past(low_cur) + 2'h1;
  endproperty
  a_lin_step: assert property (p_lin_step) // R9
    else $error("linear burst stepped out of order");

  property p_lane_drv;
    @(posedge clk) disable iff (!rst_b)
    ((ctrl_start || in_burst) && wr_lanes != ftbs_pkg::LANES_NONE)
      |=> !dq_oe;
  endproperty
  a_lane_drv: assert property (p_lane_drv) // R14
    else $error("drivers stayed on after a lane write");

  property p_adv_hold;
    @(posedge clk) disable iff (!rst_b)
    (in_burst && burst_advance_b) |=> cnt_q == $past(cnt_q);
  endproperty
  a_adv_hold: assert property (p_adv_hold) // R7
    else $error("burst address moved without advance");

  property p_oe_off;
    @(posedge clk) disable iff (!rst_b)
    output_enable_b |-> !dq_oe;
  endproperty
  a_oe_off: assert property (p_oe_off) // R22
    else $error("data driven with output enable inactive");

  property p_read_oe;
    @(posedge clk) disable iff (!rst_b)
    (state_q == ftbs_pkg::FTBS_READ && !output_enable_b && !sleep_request)
      |-> dq_oe;
  endproperty
  a_read_oe: assert property (p_read_oe) // R22
    else $error("read data not driven with output enable active");

  property p_sleep_hold;
    @(posedge clk) disable iff (!rst_b)
    sleep_request |=> state_q == $past(state_q)
      && addr_hi_q == $past(addr_hi_q);
  endproperty
  a_sleep_hold: assert property (p_sleep_hold) // R23
    else $error("state changed during sleep");

  c_proc_burst: cover property (@(posedge clk) disable iff (!rst_b)
    proc_start ##1 step [*3]);
  c_ctrl_write: cover property (@(posedge clk) disable iff (!rst_b)
    ctrl_start && wr_lanes == ftbs_pkg::LANES_ALL);
  c_lane_write: cover property (@(posedge clk) disable iff (!rst_b)
    in_burst && all_bytes_write_b && wr_lanes == 2'h1);
  c_sleep: cover property (@(posedge clk) disable iff (!rst_b)
    state_q == ftbs_pkg::FTBS_READ ##1 sleep_request [*2]);
endmodule
`default_nettype wire

// file: rtl/ftbs_pkg.sv
// Contract
// [R1] one million eighteen-bit words, data in and out sharing pins
// [R2] three selects; a cycle starts only with all active plus a strobe (controller strobe here starts one with master select inactive too)
// [R3] either strobe starts a burst; later beats use internal addresses
// [R4] processor strobe low and selected latches address, starts a read
// [R5] read word of the registered address reaches outputs same cycle
// [R6] advance ignored on processor strobe edge, sampled afterwards
// [R7] advance low with both strobes high steps the burst address
// [R8] order select high gives interleaved burst sequence
// [R9] order select low gives linear burst sequence
// [R10] host disables outputs with output enable before writing
// [R11] global write low writes all eighteen bits
// [R12] else lanes written only where lane enable and gate are low
// [R13] lane enables ignored on processor strobe edge, sampled later
// [R14] lane enable sampled low turns output drivers off
// [R15] lane enable sampled low captures data pins that edge
// [R16] write burst steps address when lane enable and advance low
// [R17] host holds processor strobe high when using controller strobe
// [R18] controller strobe cycles sample write enables on starting edge
// [R19] master select blocks processor strobe, not controller strobe
// [R20] burst counter alters only two low bits, wrapping in four words
// [R21] no lane enable asserted with global write high means read
// [R22] output enable acts asynchronously, drives only during reads
// [R23] sleep high freezes inputs, floats outputs, keeps stored data
package ftbs_pkg;
  localparam int ADDR_W  = 20;
  localparam int DATA_W  = 18;
  localparam int LANE_W  = 9;
  localparam int LANES   = 2;
  localparam int DEPTH   = 1048576;
  localparam int BURST_W = 2;
  localparam int LANE_A_LSB = 0;
  localparam int LANE_B_LSB = 9;
  localparam logic [BURST_W-1:0] CNT_RST  = 2'h0;
  localparam logic [LANES-1:0]   LANES_ALL = 2'h3;
  localparam logic [LANES-1:0]   LANES_NONE = 2'h0;

  typedef enum logic [2:0] {
    FTBS_IDLE  = 3'h1,
    FTBS_READ  = 3'h2,
    FTBS_WRITE = 3'h4
  } ftbs_state_t;
endpackage

// file: dv/ftbs_host.sv
`timescale 1ns/1ns
`default_nettype none
module ftbs_host (
  input  wire logic        clk,
  input  wire logic [17:0] dq_out,
  input  wire logic        dq_oe,
  output logic      [19:0] addr,
  output logic      [17:0] dq_in,
  output logic             proc_addr_strobe_b,
  output logic             ctrl_addr_strobe_b,
  output logic             burst_advance_b,
  output logic             all_bytes_write_b,
  output logic             byte_write_gate_b,
  output logic      [1:0]  byte_lane_writes_b,
  output logic             output_enable_b
);
  logic [17:0] drv_q = 18'h0;
  // shared data wire: device value while it drives
  assign dq_in = dq_oe ? dq_out : drv_q;
  initial begin
    {proc_addr_strobe_b, ctrl_addr_strobe_b, burst_advance_b} = 3'h7;
    {all_bytes_write_b, byte_write_gate_b, byte_lane_writes_b} = 4'hf;
    output_enable_b = 1'b0;
    addr = 20'h0;
  end
  task automatic beat(input logic ps, cs, burst_advance, gw, bg,
                      input logic [1:0] lw, input logic [19:0] a,
                      input logic [17:0] d);
    logic wr;
    @(negedge clk);
    wr = !gw || (!bg && lw != 2'h3);
    proc_addr_strobe_b = ps | ~cs;
    ctrl_addr_strobe_b = cs;
    output_enable_b = wr;
    drv_q = wr ? d : ~drv_q;
    burst_advance_b = burst_advance;
    all_bytes_write_b = gw;
    byte_write_gate_b = bg;
    byte_lane_writes_b = lw;
    addr = a;
    #1;
  endtask
endmodule
`default_nettype wire

// file: dv/ftbs_core_test.sv
`timescale 1ns/1ns
`default_nettype none
module ftbs_core_test;
  logic        clk = 1'b0, rst_b = 1'b0, order = 1'b1;
  logic        master_b = 1'b0, sel_hi = 1'b1, sleep = 1'b0;
  logic        sel_lo_b = 1'b0;
  logic [19:0] addr;
  logic [17:0] dq_in, dq_out;
  logic [17:0] mem_q [logic [19:0]];
  logic        dq_oe, proc_addr_strobe_b, ctrl_addr_strobe_b;
  logic        burst_advance_b, all_bytes_write_b, byte_write_gate_b;
  logic [1:0]  byte_lane_writes_b;
  logic        output_enable_b;
  int          failures = 0, n_compared = 0;
  always #5 clk = ~clk;
  ftbs_core i_ftbs_core (.clk(clk), .rst_b(rst_b), .addr(addr),
    .dq_in(dq_in), .dq_out(dq_out), .dq_oe(dq_oe),
    .proc_addr_strobe_b(proc_addr_strobe_b),
    .ctrl_addr_strobe_b(ctrl_addr_strobe_b),
    .burst_advance_b(burst_advance_b),
    .all_bytes_write_b(all_bytes_write_b),
    .byte_write_gate_b(byte_write_gate_b),
    .byte_lane_writes_b(byte_lane_writes_b),
    .burst_order_select(order), .master_select_b(master_b),
    .select_high(sel_hi), .select_low_b(sel_lo_b),
    .output_enable_b(output_enable_b), .sleep_request(sleep));
  ftbs_host i_ftbs_host (.clk(clk), .dq_out(dq_out), .dq_oe(dq_oe),
    .addr(addr), .dq_in(dq_in),
    .proc_addr_strobe_b(proc_addr_strobe_b),
    .ctrl_addr_strobe_b(ctrl_addr_strobe_b),
    .burst_advance_b(burst_advance_b),
    .all_bytes_write_b(all_bytes_write_b),
    .byte_write_gate_b(byte_write_gate_b),
    .byte_lane_writes_b(byte_lane_writes_b),
    .output_enable_b(output_enable_b));
  task automatic chk(input logic [17:0] got, exp);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic end_of_test;
    $display("compared %0d, failures %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  function automatic logic [19:0] ba(input logic o, input logic [19:0] a,
                                     input int i);
    return {a[19:2], o ? a[1:0] ^ 2'(i) : a[1:0] + 2'(i)};
  endfunction
  // write four beats, then read them back from a processor start
  task automatic burst(input logic o, input logic [19:0] a,
                       input logic [17:0] d);
    order = o;
    for (int i = 0; i < 4; i++) begin
      i_ftbs_host.beat(1'b1, i != 0, i == 0, i != 0, i == 0,
                       (i == 0) ? 2'h3 : 2'h0, a, d + 18'(i));
      mem_q[ba(o, a, i)] = d + 18'(i);
    end
    // lane writes and advance on this edge must be ignored
    i_ftbs_host.beat(1'b0, 1'b1, 1'b0, 1'b1, 1'b0, 2'h0, a, ~d);
    for (int i = 0; i < 4; i++) begin
      i_ftbs_host.beat(1'b1, 1'b1, i == 3, 1'b1, 1'b1, 2'h3, a, d);
      chk(dq_out, mem_q[ba(o, a, i)]);
      chk({17'h0, dq_oe}, 18'h1);
    end
  endtask
  task automatic lanes(input logic [19:0] a);
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h2, a, 18'h3ffff);
    mem_q[a][8:0] = 9'h1ff;
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h0, a, 18'h0);
    chk({17'h0, dq_oe}, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b0, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    chk(dq_out, mem_q[a]);
  endtask
  task automatic selects(input logic [19:0] a);
    sel_hi = 1'b0;
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    chk({17'h0, dq_oe}, 18'h0);
    sel_hi = 1'b1;
    master_b = 1'b1;
    i_ftbs_host.beat(1'b0, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    chk({17'h0, dq_oe}, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    chk(dq_out, mem_q[a]);
    chk({17'h0, dq_oe}, 18'h1);
    i_ftbs_host.output_enable_b = 1'b1;
    #1 chk({17'h0, dq_oe}, 18'h0);
    i_ftbs_host.output_enable_b = 1'b0;
    sleep = 1'b1;
    #1 chk({17'h0, dq_oe}, 18'h0);
    // write attempt while asleep must be dropped
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b0, 1'b1, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    sleep = 1'b0;
    #1 chk(dq_out, mem_q[a]);
    chk({17'h0, dq_oe}, 18'h1);
    sel_lo_b = 1'b1;
    i_ftbs_host.beat(1'b1, 1'b0, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    i_ftbs_host.beat(1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 2'h3, a, 18'h0);
    chk({17'h0, dq_oe}, 18'h0);
  endtask
  initial begin
    #1000000;
    failures++;
    end_of_test();
  end
  initial begin
    repeat (16) @(negedge clk);
    rst_b = 1'b1;
    burst(1'b1, 20'h12341, 18'h2a5c0);
    burst(1'b0, 20'habcd2, 18'h15a30);
    lanes(20'h12341);
    selects(20'habcd3);
    end_of_test();
  end
endmodule
`default_nettype wire
